// ==== rtl/irs_regs.vh ====
/*
  constants for the i2c target event block: register byte offsets, field
  positions, reset values and receive state codes.
  assumes a 32-bit avalon-mm slave with byte addresses and aligned words.
*/
// How it works
// - raw event status at 0x34 always shows true events, masks never touch it.
// - bit 12 sets on a repeated start while we are the addressed target.
// - repeated start flag is raised only when its enable setting is 1.
// - repeated start ahead of address (high speed, start byte) leaves flag clear.
// - bit 11 sets only when a general call address arrives and is acknowledged.
// - general call flag holds until controller disabled, its clear register is read, or 1 is written to bit 11 at 0x2c.
// - data bytes after an acknowledged general call go into the receive buffer.
// - raw flags are read-only, reset to 0, 1 means event active.
// - mask gates raw flags into masked status; restart mask resets 0, general call 1.
`ifndef IRS_REGS_VH
`define IRS_REGS_VH

// register byte offsets
`define IRS_CONTROL_OFS        8'h00
`define IRS_TARGET_ADDR_OFS    8'h08
`define IRS_RX_DATA_OFS        8'h10
`define IRS_MASKED_STATUS_OFS  8'h2c
`define IRS_EVENT_MASK_OFS     8'h30
`define IRS_RAW_STATUS_OFS     8'h34
`define IRS_GC_CLEAR_OFS       8'h40
`define IRS_RS_CLEAR_OFS       8'h44

// field positions
`define IRS_CTRL_ENABLE_BIT    0
`define IRS_CTRL_RS_EN_BIT     1
`define IRS_RS_BIT             12
`define IRS_GC_BIT             11
`define IRS_RX_VALID_BIT       8

// reset values
`define IRS_CONTROL_RST        2'h0
`define IRS_TARGET_ADDR_RST    7'h55
`define IRS_RS_MASK_RST        1'h0
`define IRS_GC_MASK_RST        1'h1
`define IRS_FLAG_RST           1'h0

// link constants
`define IRS_BITS_PER_BYTE      4'h8
`define IRS_GC_ADDR            8'h00

// receive states
`define IRS_ST_IDLE            3'h0
`define IRS_ST_ADDR            3'h1
`define IRS_ST_ADDR_ACK        3'h2
`define IRS_ST_DATA            3'h3
`define IRS_ST_DATA_ACK        3'h4
`define IRS_ST_SKIP            3'h5

`endif

// ==== rtl/irs_event_status.v ====
/*
  i2c target receiver with repeated start and general call event flags,
  raw and masked status, mask, clear-on-read registers, one interrupt.
  assumes scl and sda come from the bus asynchronously and are much slower
  than clk; software reaches the registers over avalon-mm with waitrequest.
*/
// Chosen here: the Avalon-MM register port.
`timescale 1ns/1ps
`include "irs_regs.vh"

module irs_event_status (
    // clock and reset
    input  wire        clk,
    input  wire        reset_n,
    // avalon-mm slave
    input  wire [7:0]  address,
    input  wire        read,
    input  wire        write,
    input  wire [31:0] writedata,
    output reg  [31:0] readdata,
    output reg         waitrequest,
    // i2c pins
    input  wire        scl_in,
    input  wire        sda_in,
    output reg         sda_out,
    output reg         sda_oe_n,
    // interrupt
    output reg         irq
);

    reg  [1:0]  scl_sync;
    reg  [1:0]  sda_sync;
    reg         scl_prev;
    reg         sda_prev;
    reg  [1:0]  control;
    reg  [6:0]  target_addr;
    reg         rs_mask;
    reg         gc_mask;
    reg         repeated_start_seen;
    reg         general_call_seen;
    reg  [7:0]  rx_data;
    reg         rx_full;
    reg  [2:0]  state;
    reg  [3:0]  bit_cnt;
    reg  [7:0]  shift;
    reg         addressed;
    reg         read_xfer;
    reg         gc_xfer;
    reg  [31:0] next_readdata;

    wire        scl_s      = scl_sync[1];
    wire        sda_s      = sda_sync[1];
    wire        enable     = control[`IRS_CTRL_ENABLE_BIT];
    wire        rs_enable  = control[`IRS_CTRL_RS_EN_BIT];
    wire        start_cond = scl_s & scl_prev & sda_prev & ~sda_s;
    wire        stop_cond  = scl_s & scl_prev & ~sda_prev & sda_s;
    wire        scl_rise   = scl_s & ~scl_prev;
    wire        scl_fall   = ~scl_s & scl_prev;
    wire        byte_end   = scl_fall & (bit_cnt == `IRS_BITS_PER_BYTE);
    wire        own_match  = (shift[7:1] == target_addr);
    wire        gc_match   = (shift == `IRS_GC_ADDR);
    wire        bus_wr     = write & ~waitrequest;
    wire        bus_rd     = read & ~waitrequest;
    wire        rs_pulse;
    wire        gc_pulse;
    wire        rx_write;
    wire        rx_pop     = bus_rd & (address == `IRS_RX_DATA_OFS);
    wire        gc_clear;
    wire        rs_clear;
    wire [31:0] raw_status;
    wire [31:0] mask_word;

    // raw flags never see the mask; upper bits stay zero
    assign raw_status = {19'h0, repeated_start_seen, general_call_seen, 11'h0};
    assign mask_word  = {19'h0, rs_mask, gc_mask, 11'h0};

    // repeated start only counts while addressed and enabled
    assign rs_pulse = start_cond & enable & addressed & rs_enable;
    // general call flagged when its ack is completed
    assign gc_pulse = (state == `IRS_ST_ADDR_ACK) & scl_fall & gc_xfer & ~start_cond
                      & ~stop_cond & enable;
    assign rx_write = (state == `IRS_ST_DATA) & byte_end & ~rx_full & ~start_cond
                      & ~stop_cond & enable;
    // read of clear register, disable, or w1c through masked status
    assign gc_clear = ~enable | (bus_rd & (address == `IRS_GC_CLEAR_OFS))
                      | (bus_wr & (address == `IRS_MASKED_STATUS_OFS)
                         & writedata[`IRS_GC_BIT]);
    assign rs_clear = (bus_rd & (address == `IRS_RS_CLEAR_OFS))
                      | (bus_wr & (address == `IRS_MASKED_STATUS_OFS)
                         & writedata[`IRS_RS_BIT]);

    // two-stage synchronisers for the bus lines, then an edge history stage
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
            scl_prev <= 1'h1;
            sda_prev <= 1'h1;
        end else begin
            scl_sync <= {scl_sync[0], scl_in};
            sda_sync <= {sda_sync[0], sda_in};
            scl_prev <= scl_s;
            sda_prev <= sda_s;
        end
    end

    // sticky event flags, set wins over clear
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            repeated_start_seen <= `IRS_FLAG_RST;
            general_call_seen   <= `IRS_FLAG_RST;
        end else begin
            repeated_start_seen <= rs_pulse | (repeated_start_seen & ~rs_clear);
            general_call_seen   <= gc_pulse | (general_call_seen & ~gc_clear);
        end
    end

    // target receive state machine
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state     <= `IRS_ST_IDLE;
            bit_cnt   <= 4'h0;
            shift     <= 8'h0;
            addressed <= 1'h0;
            read_xfer <= 1'h0;
            gc_xfer   <= 1'h0;
            sda_out   <= 1'h0;
            sda_oe_n  <= 1'h1;
        end else if (!enable) begin
            state     <= `IRS_ST_IDLE;
            addressed <= 1'h0;
            sda_oe_n  <= 1'h1;
        end else if (start_cond) begin
            // new address follows, so a start byte or master code is never ours
            state     <= `IRS_ST_ADDR;
            bit_cnt   <= 4'h0;
            addressed <= 1'h0;
            sda_oe_n  <= 1'h1;
        end else if (stop_cond) begin
            state     <= `IRS_ST_IDLE;
            addressed <= 1'h0;
            sda_oe_n  <= 1'h1;
        end else begin
            if (scl_rise && (state == `IRS_ST_ADDR || state == `IRS_ST_DATA)) begin
                shift   <= {shift[6:0], sda_s};
                bit_cnt <= bit_cnt + 4'h1;
            end
            case (state)
                `IRS_ST_IDLE: begin
                    sda_oe_n <= 1'h1;
                end
                `IRS_ST_ADDR: begin
                    if (byte_end) begin
                        bit_cnt <= 4'h0;
                        if (own_match || gc_match) begin
                            state     <= `IRS_ST_ADDR_ACK;
                            sda_oe_n  <= 1'h0; // pull low to acknowledge
                            addressed <= 1'h1;
                            read_xfer <= shift[0];
                            gc_xfer   <= gc_match;
                        end else begin
                            state <= `IRS_ST_SKIP;
                        end
                    end
                end
                `IRS_ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        sda_oe_n <= 1'h1;
                        state    <= read_xfer ? `IRS_ST_SKIP : `IRS_ST_DATA;
                    end
                end
                `IRS_ST_DATA: begin
                    if (byte_end) begin
                        bit_cnt <= 4'h0;
                        // general call data lands like any other byte
                        if (!rx_full) begin
                            state    <= `IRS_ST_DATA_ACK;
                            sda_oe_n <= 1'h0;
                        end else begin
                            state <= `IRS_ST_SKIP;
                        end
                    end
                end
                `IRS_ST_DATA_ACK: begin
                    if (scl_fall) begin
                        sda_oe_n <= 1'h1;
                        state    <= `IRS_ST_DATA;
                    end
                end
                `IRS_ST_SKIP: begin
                    sda_oe_n <= 1'h1;
                end
                default: begin
                    state    <= `IRS_ST_IDLE;
                    sda_oe_n <= 1'h1;
                end
            endcase
        end
    end

    // one-byte receive buffer, popped by reading the data register
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_data <= 8'h0;
            rx_full <= 1'h0;
        end else if (rx_write) begin
            rx_data <= shift;
            rx_full <= 1'h1;
        end else if (rx_pop) begin
            rx_full <= 1'h0;
        end
    end

    // software control registers; raw status has no write path
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            control     <= `IRS_CONTROL_RST;
            target_addr <= `IRS_TARGET_ADDR_RST;
            rs_mask     <= `IRS_RS_MASK_RST;
            gc_mask     <= `IRS_GC_MASK_RST;
        end else if (bus_wr) begin
            case (address)
                `IRS_CONTROL_OFS:     control     <= writedata[1:0];
                `IRS_TARGET_ADDR_OFS: target_addr <= writedata[6:0];
                `IRS_EVENT_MASK_OFS: begin
                    rs_mask <= writedata[`IRS_RS_BIT];
                    gc_mask <= writedata[`IRS_GC_BIT];
                end
                default: begin
                    control <= control;
                end
            endcase
        end
    end

    // read mux; unmapped offsets read zero
    always @* begin
        next_readdata = 32'h0;
        case (address)
            `IRS_CONTROL_OFS:       next_readdata = {30'h0, control};
            `IRS_TARGET_ADDR_OFS:   next_readdata = {25'h0, target_addr};
            `IRS_RX_DATA_OFS:       next_readdata = {23'h0, rx_full, rx_data};
            `IRS_MASKED_STATUS_OFS: next_readdata = raw_status & mask_word;
            `IRS_EVENT_MASK_OFS:    next_readdata = mask_word;
            `IRS_RAW_STATUS_OFS:    next_readdata = raw_status;
            `IRS_GC_CLEAR_OFS:      next_readdata = {31'h0, general_call_seen};
            `IRS_RS_CLEAR_OFS:      next_readdata = {31'h0, repeated_start_seen};
            default:                next_readdata = 32'h0;
        endcase
    end

    // answer one cycle after a request is seen, then rearm
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            waitrequest <= 1'h1;
            readdata    <= 32'h0;
            irq         <= 1'h0;
        end else begin
            waitrequest <= ~((read | write) & waitrequest);
            if ((read | write) && waitrequest) begin
                readdata <= read ? next_readdata : 32'h0;
            end
            irq <= |(raw_status & mask_word);
        end
    end

endmodule // irs_event_status

// ==== verif/irs_checker.sv ====
/* port checker for the target event block.
   assumes it is bound to irs_event_status and sees only its ports. */
`timescale 1ns/1ps
`include "irs_regs.vh"
module irs_checker (
    // clock and reset
    input wire logic        clk,
    input wire logic        reset_n,
    // avalon-mm slave
    input wire logic [7:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] writedata,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    // i2c pins and interrupt
    input wire logic        scl_in,
    input wire logic        sda_in,
    input wire logic        sda_out,
    input wire logic        sda_oe_n,
    input wire logic        irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // a read answered in this cycle
    wire rd_ok = read && !waitrequest;
    chk_answer_next: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("request not answered next cycle");
    chk_answer_pulse: assert property (!waitrequest |=> waitrequest)
        else $error("answer held too long");
    chk_reset_quiet: assert property ($rose(reset_n) |-> waitrequest && !irq && sda_oe_n)
        else $error("outputs busy after reset");
    chk_raw_reserved: assert property (rd_ok && address == `IRS_RAW_STATUS_OFS
        |-> readdata[31:13] == 19'h0 && readdata[10:0] == 11'h0)
        else $error("raw status spare bits set");
    chk_gc_clear_bit: assert property (rd_ok && address == `IRS_GC_CLEAR_OFS
        |-> readdata[31:1] == 31'h0)
        else $error("clear register spare bits set");
    chk_masked_bits: assert property (rd_ok && address == `IRS_MASKED_STATUS_OFS
        |-> (readdata & ~32'h1800) == 32'h0)
        else $error("masked status spare bits set");
    chk_mask_blocks: assert property (write && !waitrequest
        && address == `IRS_EVENT_MASK_OFS && writedata[12:11] == 2'h0 |-> ##2 !irq)
        else $error("interrupt passes a zero mask");
    chk_ack_hold: assert property ($fell(sda_oe_n) |=> !sda_oe_n [*3])
        else $error("acknowledge too short");
endmodule // irs_checker

bind irs_event_status irs_checker u_chk (.clk(clk), .reset_n(reset_n), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .irq(irq));

// ==== verif/irs_i2c_master.sv ====
/* i2c bus master model driving the target block.
   assumes the bench resolves sda as open drain with a pull-up. */
`timescale 1ns/1ps
module irs_i2c_master (
    // bus lines
    output logic      scl,
    output logic      sda_drv,
    input  wire logic sda_line
);
    // lines idle high; scl stands still between frames
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    // start or repeated start, offset from the block clock edges; scl rises only
    // after the target has let go of its acknowledge, or a false stop is seen
    task start;
        #13 sda_drv = 1'b1;
        #400 scl = 1'b1;
        #200 sda_drv = 1'b0;
        #200 scl = 1'b0;
    endtask
    // stop: sda rises while scl high
    task stop;
        #200 sda_drv = 1'b0;
        #200 scl = 1'b1;
        #200 sda_drv = 1'b1;
    endtask
    // eight bits msb first, then sample the acknowledge
    task xfer(input logic [7:0] b, output logic ack);
        integer i;
        for (i = 7; i >= 0; i--) begin
            #200 sda_drv = b[i];
            #200 scl = 1'b1;
            #400 scl = 1'b0;
        end
        #200 sda_drv = 1'b1;
        #200 scl = 1'b1;
        #200 ack = !sda_line;
        #200 scl = 1'b0;
    endtask
endmodule // irs_i2c_master

// ==== verif/irs_event_status_tb.sv ====
/* self-checking bench for the target event block.
   assumes irs_event_status, the master model and a pulled-up sda. */
`timescale 1ns/1ps
`include "irs_regs.vh"
module irs_event_status_tb;
    // stimulus, observation and model state
    logic        clk, reset_n, read, write, ack;
    logic [7:0]  address;
    logic [31:0] writedata, q;
    logic [15:0] rnd = 16'h6694;
    logic [7:0]  rxq[$];
    wire  [31:0] readdata;
    wire         waitrequest, sda_out, sda_oe_n, irq, scl, sda_drv;
    wire         sda_line = sda_drv & (sda_oe_n | sda_out);
    integer      err_count = 0, tests_run = 0, m_raw = 0;

    irs_event_status u_dut (.clk(clk), .reset_n(reset_n), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .irq(irq));
    irs_i2c_master u_mst (.scl(scl), .sda_drv(sda_drv), .sda_line(sda_line));

    // 10 mhz clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one avalon transfer, held until waitrequest is sampled low
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        integer n;
        @(posedge clk);
        address <= a;
        read <= !wr;
        write <= wr;
        writedata <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 20);
        q = readdata;
        if (n >= 20) err_count++;
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(q, e);
    endtask
    // address frame, optionally a repeated start and our address again
    task frame(input logic [7:0] a, input logic rs, input logic ea);
        u_mst.start;
        u_mst.xfer(a, ack);
        chk(ack, ea);
        if (rs) begin
            u_mst.start;
            u_mst.xfer(8'haa, ack);
        end
        u_mst.stop;
    endtask
    task summarize;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // watchdog
    initial begin
        #1000000;
        err_count++;
        summarize;
    end
    // main sequence
    initial begin
        reset_n = 1'b0;
        read = 1'b0;
        write = 1'b0;
        address = 8'h0;
        writedata = 32'h0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        rd(`IRS_RAW_STATUS_OFS, 32'h0);
        rd(`IRS_EVENT_MASK_OFS, 32'h800);
        rd(8'h3c, 32'h0);
        bus(1'b1, `IRS_RAW_STATUS_OFS, 32'hffffffff);
        rd(`IRS_RAW_STATUS_OFS, 32'h0);
        bus(1'b1, `IRS_CONTROL_OFS, 32'h1);
        // general call followed by a random data byte
        rnd = lfsr(rnd);
        rxq.push_back(rnd[7:0]);
        u_mst.start;
        u_mst.xfer(8'h00, ack);
        chk(ack, 1'b1);
        u_mst.xfer(rnd[7:0], ack);
        chk(ack, 1'b1);
        u_mst.stop;
        m_raw = 32'h800;
        rd(`IRS_RAW_STATUS_OFS, m_raw);
        chk(irq, 1'b1);
        rd(`IRS_RX_DATA_OFS, {23'h0, 1'b1, rxq.pop_front()});
        rd(`IRS_MASKED_STATUS_OFS, 32'h800);
        bus(1'b1, `IRS_EVENT_MASK_OFS, 32'h0);
        rd(`IRS_RAW_STATUS_OFS, m_raw);
        chk(irq, 1'b0);
        rd(`IRS_GC_CLEAR_OFS, 32'h1);
        m_raw = 0;
        rd(`IRS_RAW_STATUS_OFS, m_raw);
        frame(8'h44, 1'b0, 1'b0);
        frame(8'haa, 1'b1, 1'b1);
        rd(`IRS_RAW_STATUS_OFS, m_raw);
        bus(1'b1, `IRS_CONTROL_OFS, 32'h3);
        frame(8'haa, 1'b1, 1'b1);
        rd(`IRS_RAW_STATUS_OFS, 32'h1000);
        rd(`IRS_RS_CLEAR_OFS, 32'h1);
        frame(8'h01, 1'b1, 1'b0);
        rd(`IRS_RAW_STATUS_OFS, m_raw);
        frame(8'h00, 1'b0, 1'b1);
        bus(1'b1, `IRS_CONTROL_OFS, 32'h0);
        rd(`IRS_RAW_STATUS_OFS, m_raw);
        summarize;
    end
endmodule // irs_event_status_tb
